//--- logic/blm_processing.sv
`include "blm_map.svh"
module blm_processing
  import blm_pkg::*;
#(
  parameter int W = `ADC_W,
  parameter int N = `NCH,
  parameter int DEPTH = `BUF_DEPTH,
  parameter int AW = `BUF_AW
) (
  input wire logic SYS_CLK,
  input wire logic RST_N,
  input wire logic [N*W-1:0] ADC_DATA,
  input wire logic EXT_TRIG,
  input wire logic PM_TRIG,
  input wire logic TRIG_SEL,
  input wire logic [N*W-1:0] OFFSET,
  input wire logic [N*W-1:0] LOSS_LEVEL,
  input wire logic [N*4-1:0] CH_DELAY,
  input wire logic [N*8-1:0] ATTEN_GAIN,
  input wire logic [N*8-1:0] DYN_GAIN,
  input wire logic [N*8-1:0] STAT_GAIN,
  input wire logic [N-1:0] COINC_SEL,
  input wire logic [7:0] COINC_WIN,
  input wire logic [N-1:0] MASK_A,
  input wire logic [N-1:0] MASK_B,
  input wire logic [7:0] INT_LEN,
  input wire logic AVG_MODE,
  input wire logic [7:0] DECIM,
  input wire logic [W+1:0] AUTO_THR,
  input wire logic ILK_EN,
  input wire logic [W-1:0] ILK_LIMIT,
  input wire logic [N*8-1:0] GAIN_CTRL_SET,
  input wire logic [N-1:0] SUPPLY_EN_SET,
  input wire logic [4:0] FLAG_CLR,
  input wire logic [AW-1:0] RD_ADDR,
  output logic [N*W-1:0] RAW_RD,
  output logic [W+9:0] PROC_A_RD,
  output logic [W+9:0] PROC_B_RD,
  output logic [N*W-1:0] PM_RD,
  output logic [AW-1:0] PM_WPTR,
  output logic [N*16-1:0] LOSS_COUNT,
  output logic [N*(W+16)-1:0] LOSS_CAL,
  output logic [N*8-1:0] GAIN_CTRL,
  output logic [N-1:0] SUPPLY_EN,
  output logic COINC,
  output logic MASK_A_LOSS,
  output logic MASK_B_LOSS,
  output logic INTERLOCK,
  output logic CAP_BUSY,
  output logic [4:0] FLAGS
);
  ////////////////////////////////////////////////////////////////////
  // Input synchronisers
  logic trig_s1_r, trig_s2_r, trig_s3_r, pm_s1_r, pm_s2_r, pm_s3_r;
  always_ff @(posedge SYS_CLK)
  begin
    trig_s1_r <= EXT_TRIG;
    trig_s2_r <= trig_s1_r;
    trig_s3_r <= trig_s2_r;
    pm_s1_r <= PM_TRIG;
    pm_s2_r <= pm_s1_r;
    pm_s3_r <= pm_s2_r;
  end
  wire ext_edge = trig_s2_r & ~trig_s3_r;
  wire pm_edge = pm_s2_r & ~pm_s3_r;

  ////////////////////////////////////////////////////////////////////
  // Per-channel loss counting
  logic [W-1:0] corr [N];
  logic [N-1:0] loss;
  logic [N-1:0] over_ilk;
  genvar g;
  generate
    for (g = 0; g < N; g++)
    begin : ch
      wire [15:0] gain_w = {8'h00, ATTEN_GAIN[g*8 +: 8]} + {8'h00, DYN_GAIN[g*8 +: 8]}
        + {8'h00, STAT_GAIN[g*8 +: 8]};
      loss_channel #(.W(W)) u_ch (
        .clk(SYS_CLK),
        .rst_n(RST_N),
        .adc(ADC_DATA[g*W +: W]),
        .offset(OFFSET[g*W +: W]),
        .level(LOSS_LEVEL[g*W +: W]),
        .delay(CH_DELAY[g*4 +: 4]),
        .gain(gain_w),
        .corr(corr[g]),
        .cal(LOSS_CAL[g*(W+16) +: W+16]),
        .loss(loss[g]),
        .count(LOSS_COUNT[g*16 +: 16])
      );
      assign over_ilk[g] = ADC_DATA[g*W +: W] > ILK_LIMIT;
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////
  // Coincidence window
  logic [7:0] win_r [N];
  logic [N-1:0] recent;
  always_ff @(posedge SYS_CLK)
  begin
    for (int i = 0; i < N; i++)
      if (!RST_N)
        win_r[i] <= 8'h00;
      else if (loss[i])
        win_r[i] <= COINC_WIN;
      else if (win_r[i] != 8'h00)
        win_r[i] <= win_r[i] - 8'h01;
  end
  always_comb
  begin
    for (int i = 0; i < N; i++)
      recent[i] = loss[i] | (win_r[i] != 8'h00);
  end
  wire coinc_w = (COINC_SEL != '0) && ((recent & COINC_SEL) == COINC_SEL);
  wire ma_w = |(loss & MASK_A);
  wire mb_w = |(loss & MASK_B);

  ////////////////////////////////////////////////////////////////////
  // Post-processing: integrate/average, decimation, mask
  logic [W+1:0] sum_a, sum_b;
  always_comb
  begin
    sum_a = '0;
    sum_b = '0;
    for (int i = 0; i < N; i++)
    begin
      if (MASK_A[i])
        sum_a = sum_a + (W+2)'(corr[i]);
      if (MASK_B[i])
        sum_b = sum_b + (W+2)'(corr[i]);
    end
  end
  logic [W+9:0] acc_a_r, acc_b_r, res_a_r, res_b_r;
  logic [7:0] int_cnt_r, dec_cnt_r;
  logic res_vld_r;
  wire [7:0] int_len = (INT_LEN == 8'h00) ? 8'h01 : INT_LEN;
  wire int_end = int_cnt_r >= int_len - 8'h01;
  wire [W+9:0] out_a = AVG_MODE ? (acc_a_r + (W+10)'(sum_a)) / (W+10)'(int_len)
    : acc_a_r + (W+10)'(sum_a);
  wire [W+9:0] out_b = AVG_MODE ? (acc_b_r + (W+10)'(sum_b)) / (W+10)'(int_len)
    : acc_b_r + (W+10)'(sum_b);
  always_ff @(posedge SYS_CLK)
  begin
    if (!RST_N)
    begin
      acc_a_r <= '0;
      acc_b_r <= '0;
      res_a_r <= '0;
      res_b_r <= '0;
      int_cnt_r <= 8'h00;
      dec_cnt_r <= 8'h00;
      res_vld_r <= 1'b0;
    end
    else
    begin
      res_vld_r <= 1'b0;
      if (int_end)
      begin
        acc_a_r <= '0;
        acc_b_r <= '0;
        int_cnt_r <= 8'h00;
        if (dec_cnt_r >= DECIM)
        begin
          dec_cnt_r <= 8'h00;
          res_a_r <= out_a;
          res_b_r <= out_b;
          res_vld_r <= 1'b1;
        end
        else
          dec_cnt_r <= dec_cnt_r + 8'h01;
      end
      else
      begin
        acc_a_r <= acc_a_r + (W+10)'(sum_a);
        acc_b_r <= acc_b_r + (W+10)'(sum_b);
        int_cnt_r <= int_cnt_r + 8'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Trigger selection and capture
  wire auto_hit = sum_a > AUTO_THR;
  logic auto_d_r;
  always_ff @(posedge SYS_CLK)
    auto_d_r <= RST_N & auto_hit;
  wire auto_edge = auto_hit & ~auto_d_r;
  wire sel_trig = (trig_src_t'(TRIG_SEL) == TRIG_SIG) ? auto_edge : ext_edge;
  wire start = sel_trig | auto_edge;
  cap_state_t st_r, st_nxt;
  logic [AW-1:0] raw_ptr_r, proc_ptr_r;
  logic [N*W-1:0] raw_mem [DEPTH];
  logic [W+9:0] pa_mem [DEPTH];
  logic [W+9:0] pb_mem [DEPTH];
  logic [N*W-1:0] corr_bus;
  always_comb
  begin
    for (int i = 0; i < N; i++)
      corr_bus[i*W +: W] = corr[i];
  end
  wire raw_last = raw_ptr_r == AW'(DEPTH - 1);
  always_comb
  begin
    st_nxt = st_r;
    unique case (st_r)
      CAP_IDLE: if (start) st_nxt = CAP_RUN;
      CAP_RUN: if (raw_last) st_nxt = CAP_DONE;
      CAP_DONE: if (start) st_nxt = CAP_RUN;
      default: st_nxt = CAP_IDLE;
    endcase
  end
  wire run = st_r == CAP_RUN;
  always_ff @(posedge SYS_CLK)
  begin
    if (!RST_N)
    begin
      st_r <= CAP_IDLE;
      raw_ptr_r <= '0;
      proc_ptr_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
      if (!run)
      begin
        raw_ptr_r <= '0;
        proc_ptr_r <= '0;
      end
      else
      begin
        raw_ptr_r <= raw_ptr_r + AW'(1);
        if (res_vld_r)
          proc_ptr_r <= proc_ptr_r + AW'(1);
      end
    end
  end
  always_ff @(posedge SYS_CLK)
  begin
    if (run)
      raw_mem[raw_ptr_r] <= ADC_DATA;
    if (run && res_vld_r)
    begin
      pa_mem[proc_ptr_r] <= res_a_r;
      pb_mem[proc_ptr_r] <= res_b_r;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Postmortem ring, frozen PRE_TRIG samples after the event
  logic [N*W-1:0] pm_mem [`PM_DEPTH];
  logic [AW-1:0] pm_ptr_r;
  logic [AW-1:0] pm_post_r;
  logic pm_frz_r, pm_arm_r;
  always_ff @(posedge SYS_CLK)
  begin
    if (!RST_N)
    begin
      pm_ptr_r <= '0;
      pm_post_r <= '0;
      pm_frz_r <= 1'b0;
      pm_arm_r <= 1'b0;
    end
    else if (!pm_frz_r)
    begin
      pm_ptr_r <= pm_ptr_r + AW'(1);
      if (pm_edge)
        pm_arm_r <= 1'b1;
      if (pm_arm_r || pm_edge)
      begin
        pm_post_r <= pm_post_r + AW'(1);
        if (pm_post_r == AW'(`PRE_TRIG))
          pm_frz_r <= 1'b1;
      end
    end
    else if (FLAG_CLR[4])
    begin
      pm_frz_r <= 1'b0;
      pm_arm_r <= 1'b0;
      pm_post_r <= '0;
    end
  end
  always_ff @(posedge SYS_CLK)
    if (!pm_frz_r)
      pm_mem[pm_ptr_r] <= corr_bus;

  ////////////////////////////////////////////////////////////////////
  // Outputs, interlock and flags
  logic [4:0] flags_r;
  wire [4:0] ev = {pm_frz_r, INTERLOCK, start, coinc_w, auto_hit};
  always_ff @(posedge SYS_CLK)
  begin
    if (!RST_N)
    begin
      flags_r <= 5'h00;
      INTERLOCK <= 1'b0;
      COINC <= 1'b0;
      MASK_A_LOSS <= 1'b0;
      MASK_B_LOSS <= 1'b0;
      GAIN_CTRL <= '0;
      SUPPLY_EN <= '0;
      RAW_RD <= '0;
      PROC_A_RD <= '0;
      PROC_B_RD <= '0;
      PM_RD <= '0;
    end
    else
    begin
      flags_r <= (flags_r & ~FLAG_CLR) | ev;
      INTERLOCK <= ILK_EN & (|over_ilk);
      COINC <= coinc_w;
      MASK_A_LOSS <= ma_w;
      MASK_B_LOSS <= mb_w;
      GAIN_CTRL <= GAIN_CTRL_SET;
      SUPPLY_EN <= SUPPLY_EN_SET;
      RAW_RD <= raw_mem[RD_ADDR];
      PROC_A_RD <= pa_mem[RD_ADDR];
      PROC_B_RD <= pb_mem[RD_ADDR];
      PM_RD <= pm_mem[RD_ADDR];
    end
  end
  assign FLAGS = flags_r;
  assign PM_WPTR = pm_ptr_r;
  assign CAP_BUSY = run;
endmodule // blm_processing

//--- logic/blm_map.svh
`ifndef BLM_MAP_SVH
`define BLM_MAP_SVH
`define SAMPLE_PERIOD_NS 8
`define CLK_PERIOD_NS 25
`define ADC_W 14
`define NCH 4
`define BUF_DEPTH 64
`define BUF_AW 6
`define PM_DEPTH 64
`define PRE_TRIG 16
`define GAIN_FRAC 8
`endif

//--- logic/blm_pkg.sv
package blm_pkg;
  typedef enum logic [1:0] {
    CAP_IDLE = 2'b00,
    CAP_RUN = 2'b01,
    CAP_DONE = 2'b10
  } cap_state_t;
  typedef enum logic {
    TRIG_EXT = 1'b0,
    TRIG_SIG = 1'b1
  } trig_src_t;
endpackage

//--- logic/loss_channel.sv
`include "blm_map.svh"
module loss_channel #(
  parameter int W = 14,
  parameter int DLY_MAX = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] adc,
  input wire logic [W-1:0] offset,
  input wire logic [W-1:0] level,
  input wire logic [3:0] delay,
  input wire logic [15:0] gain,
  output logic [W-1:0] corr,
  output logic [W+15:0] cal,
  output logic loss,
  output logic [15:0] count
);
  logic [W-1:0] dly_r [DLY_MAX];
  logic [W-1:0] sub;
  assign sub = (adc > offset) ? adc - offset : '0;
  always_ff @(posedge clk)
  begin
    dly_r[0] <= sub;
    for (int i = 1; i < DLY_MAX; i++)
      dly_r[i] <= dly_r[i-1];
  end
  assign corr = dly_r[delay];
  assign loss = corr > level;
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      count <= 16'h0000;
      cal <= '0;
    end
    else
    begin
      if (loss && count != 16'hffff)
        count <= count + 16'h0001;
      cal <= corr * gain;
    end
  end
endmodule // loss_channel

//--- verification/det_model.sv
module det_model (
  input wire logic clk,
  input wire logic ramp,
  input wire logic [3:0] hit,
  output logic [55:0] adc
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [13:0] t_r = 14'h0000;
  always_ff @(posedge clk)
    t_r <= t_r + 14'h0001;
  // New sample each clock; ramp ties all channels to one counter, 256 apart, hit mode is per channel
  always_comb
    for (int i = 0; i < 4; i++)
      adc[i*14 +: 14] = ramp ? t_r + 14'(i * 256) : (hit[i] ? 14'h0fa0 : 14'h0000);
endmodule // det_model

//--- verification/blm_processing_props.sv
module blm_processing_props #(
  parameter int W = 14,
  parameter int N = 4
) (
  input wire logic SYS_CLK,
  input wire logic RST_N,
  input wire logic [N*W-1:0] ADC_DATA,
  input wire logic EXT_TRIG,
  input wire logic TRIG_SEL,
  input wire logic ILK_EN,
  input wire logic [W-1:0] ILK_LIMIT,
  input wire logic [N*8-1:0] GAIN_CTRL_SET,
  input wire logic [N-1:0] SUPPLY_EN_SET,
  input wire logic [4:0] FLAG_CLR,
  input wire logic [N*8-1:0] GAIN_CTRL,
  input wire logic [N-1:0] SUPPLY_EN,
  input wire logic INTERLOCK,
  input wire logic CAP_BUSY,
  input wire logic [4:0] FLAGS
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!RST_N);
  logic over;
  logic [7:0] busy_r;
  always_comb
  begin
    over = 1'b0;
    for (int i = 0; i < N; i++)
      over = over | (ADC_DATA[i*W +: W] > ILK_LIMIT);
  end
  always_ff @(posedge SYS_CLK)
    busy_r <= (!RST_N || !CAP_BUSY) ? 8'h00 : busy_r + 8'h01;
  ////////////////////////////////////////
  a_gain_follow: assert property ($past(RST_N) |-> GAIN_CTRL == $past(GAIN_CTRL_SET))
    else $error("gain control lost");
  a_supply_follow: assert property ($past(RST_N) |-> SUPPLY_EN == $past(SUPPLY_EN_SET))
    else $error("supply enable lost");
  a_ilk_raise: assert property (ILK_EN && over |-> ##[1:2] INTERLOCK)
    else $error("interlock missing");
  a_ilk_off: assert property (!ILK_EN [*2] |=> !INTERLOCK)
    else $error("interlock while disabled");
  a_flag_hold: assert property ($past(RST_N) |-> (~FLAGS & $past(FLAGS & ~FLAG_CLR)) == 5'h00)
    else $error("flag dropped");
  a_ilk_flag: assert property ($rose(INTERLOCK) |-> ##[0:1] FLAGS[3])
    else $error("interlock flag missing");
  a_cap_len: assert property ($fell(CAP_BUSY) |-> busy_r == 8'h40)
    else $error("capture length wrong");
  a_cap_max: assert property (busy_r <= 8'h40)
    else $error("capture too long");
  a_cap_flag: assert property ($rose(CAP_BUSY) |-> FLAGS[2])
    else $error("capture flag missing");
  a_ext_start: assert property ($rose(EXT_TRIG) && !TRIG_SEL && !CAP_BUSY |-> ##[1:5] CAP_BUSY)
    else $error("external trigger lost");
  c_cap: cover property ($rose(CAP_BUSY));
  c_ilk: cover property ($rose(INTERLOCK));
  c_clr: cover property ($fell(FLAGS[1]));
endmodule // blm_processing_props
bind blm_processing blm_processing_props #(.W(W), .N(N)) u_props (.SYS_CLK(SYS_CLK),
  .RST_N(RST_N), .ADC_DATA(ADC_DATA), .EXT_TRIG(EXT_TRIG), .TRIG_SEL(TRIG_SEL),
  .ILK_EN(ILK_EN), .ILK_LIMIT(ILK_LIMIT), .GAIN_CTRL_SET(GAIN_CTRL_SET),
  .SUPPLY_EN_SET(SUPPLY_EN_SET), .FLAG_CLR(FLAG_CLR), .GAIN_CTRL(GAIN_CTRL),
  .SUPPLY_EN(SUPPLY_EN), .INTERLOCK(INTERLOCK), .CAP_BUSY(CAP_BUSY), .FLAGS(FLAGS));

//--- verification/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import blm_pkg::*;
  logic SYS_CLK = 1'b0, RST_N = 1'b0, EXT_TRIG = 1'b0, PM_TRIG = 1'b0, TRIG_SEL = 1'b0;
  logic ILK_EN = 1'b0, AVG_MODE = 1'b0, ramp = 1'b0;
  logic [3:0] COINC_SEL = 4'h0, MASK_A = 4'h0, MASK_B = 4'h2, SUPPLY_EN_SET = 4'h0;
  logic [3:0] hit = 4'h0;
  logic [4:0] FLAG_CLR = 5'h00;
  logic [5:0] RD_ADDR = 6'h00;
  logic [7:0] COINC_WIN = 8'h10, INT_LEN = 8'h04, DECIM = 8'h01;
  logic [13:0] ILK_LIMIT = 14'h0064;
  logic [15:0] AUTO_THR = 16'hffff, CH_DELAY = 16'h0000;
  logic [31:0] ATTEN_GAIN = 32'h40404040, DYN_GAIN = 32'h40404040;
  logic [31:0] STAT_GAIN = 32'h40404040, GAIN_CTRL_SET = 32'h00000000;
  logic [55:0] OFFSET = 56'h0, LOSS_LEVEL = {4{14'h0032}};
  wire [55:0] ADC_DATA, RAW_RD;
  wire [63:0] LOSS_COUNT;
  wire [31:0] GAIN_CTRL;
  wire [3:0] SUPPLY_EN;
  wire [4:0] FLAGS;
  wire [23:0] PROC_A_RD, PROC_B_RD;
  wire [55:0] PM_RD;
  wire [5:0] PM_WPTR;
  wire [119:0] LOSS_CAL;
  wire COINC, MASK_A_LOSS, MASK_B_LOSS, INTERLOCK, CAP_BUSY;
  wire [9:0] mon = {FLAGS, COINC, MASK_A_LOSS, MASK_B_LOSS, INTERLOCK, CAP_BUSY};
  int err_total = 0;
  int tests_run = 0;
  det_model det (.clk(SYS_CLK), .ramp, .hit, .adc(ADC_DATA));
  blm_processing uut (.SYS_CLK, .RST_N, .ADC_DATA, .EXT_TRIG, .PM_TRIG, .TRIG_SEL, .OFFSET,
    .LOSS_LEVEL, .CH_DELAY, .ATTEN_GAIN, .DYN_GAIN, .STAT_GAIN, .COINC_SEL, .COINC_WIN,
    .MASK_A, .MASK_B, .INT_LEN, .AVG_MODE, .DECIM, .AUTO_THR, .ILK_EN, .ILK_LIMIT,
    .GAIN_CTRL_SET, .SUPPLY_EN_SET, .FLAG_CLR, .RD_ADDR, .RAW_RD, .PROC_A_RD, .PROC_B_RD,
    .PM_RD, .PM_WPTR, .LOSS_COUNT, .LOSS_CAL, .GAIN_CTRL, .SUPPLY_EN, .COINC,
    .MASK_A_LOSS, .MASK_B_LOSS, .INTERLOCK, .CAP_BUSY, .FLAGS);
  always #12.5 SYS_CLK = ~SYS_CLK;
  ////////////////////////////////////////
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge SYS_CLK);
  endtask
  task automatic seen(input int idx, input int n, input logic exp);
    logic f;
    f = 1'b0;
    repeat (n)
    begin
      @(negedge SYS_CLK);
      f = f | (mon[idx] === 1'b1);
    end
    chk(f, exp);
  endtask
  task automatic fin(input string s);
    $display("test %s done, mismatches %0d", s, err_total);
  endtask
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic rd(input logic [5:0] a, output logic [55:0] d);
    @(posedge SYS_CLK);
    RD_ADDR <= a;
    cyc(1);
    @(negedge SYS_CLK);
    d = RAW_RD;
  endtask
  ////////////////////////////////////////
  task automatic t_ctrl();
    @(negedge SYS_CLK);
    chk({FLAGS, CAP_BUSY, INTERLOCK, SUPPLY_EN, GAIN_CTRL}, 0);
    @(posedge SYS_CLK);
    GAIN_CTRL_SET <= 32'ha5c37e19;
    SUPPLY_EN_SET <= 4'h9;
    cyc(2);
    @(negedge SYS_CLK);
    chk({SUPPLY_EN, GAIN_CTRL}, 36'h9a5c37e19);
    fin("ctrl");
  endtask
  task automatic t_ilk();
    @(posedge SYS_CLK);
    hit <= 4'h4;
    seen(1, 6, 1'b0);
    chk(LOSS_COUNT[15:0], 0);
    chk(LOSS_COUNT[47:32] != 0, 1);
    chk(LOSS_CAL[89:60], 30'h000bb800);
    @(posedge SYS_CLK);
    ILK_EN <= 1'b1;
    seen(1, 4, 1'b1);
    chk(FLAGS[3], 1);
    @(posedge SYS_CLK);
    hit <= 4'h0;
    ILK_EN <= 1'b0;
    FLAG_CLR <= 5'h08;
    cyc(4);
    FLAG_CLR <= 5'h00;
    @(negedge SYS_CLK);
    chk(FLAGS[3], 0);
    fin("interlock");
  endtask
  task automatic t_coinc();
    @(posedge SYS_CLK);
    COINC_SEL <= 4'h3;
    COINC_WIN <= 8'h08;
    hit <= 4'h1;
    cyc(1);
    hit <= 4'h0;
    cyc(20);
    hit <= 4'h2;
    cyc(1);
    hit <= 4'h0;
    seen(4, 12, 1'b0);
    @(posedge SYS_CLK);
    hit <= 4'h1;
    cyc(1);
    hit <= 4'h2;
    cyc(1);
    hit <= 4'h0;
    seen(4, 12, 1'b1);
    chk(FLAGS[1], 1);
    @(posedge SYS_CLK);
    MASK_A <= 4'h4;
    hit <= 4'h3;
    seen(2, 8, 1'b1);
    seen(3, 8, 1'b0);
    @(posedge SYS_CLK);
    hit <= 4'h0;
    fin("coinc");
  endtask
  task automatic t_cap();
    logic [55:0] prev, cur, nx;
    logic [23:0] pa, pb;
    @(posedge SYS_CLK);
    ramp <= 1'b1;
    EXT_TRIG <= 1'b1;
    cyc(2);
    EXT_TRIG <= 1'b0;
    seen(0, 8, 1'b1);
    chk(FLAGS[2], 1);
    @(posedge SYS_CLK);
    EXT_TRIG <= 1'b1;
    cyc(2);
    EXT_TRIG <= 1'b0;
    cyc(70);
    @(negedge SYS_CLK);
    chk(CAP_BUSY, 0);
    rd(6'h00, prev);
    chk(14'(prev[27:14] - prev[13:0]), 14'h0100);
    for (int a = 1; a < 64; a++)
    begin
      rd(6'(a), cur);
      for (int c = 0; c < 4; c++)
        nx[c*14 +: 14] = prev[c*14 +: 14] + 14'h0001;
      chk(cur, nx);
      prev = cur;
    end
    rd(6'h01, cur);
    pa = PROC_A_RD;
    pb = PROC_B_RD;
    rd(6'h02, cur);
    chk(24'(PROC_A_RD - pa), 24'h000020);
    chk(24'(PROC_B_RD - pb), 24'h000020);
    fin("capture");
  endtask
  task automatic t_sel();
    logic [55:0] cur;
    logic [23:0] pa;
    @(posedge SYS_CLK);
    TRIG_SEL <= 1'b1;
    EXT_TRIG <= 1'b1;
    AVG_MODE <= 1'b1;
    DECIM <= 8'h00;
    INT_LEN <= 8'h00;
    cyc(2);
    EXT_TRIG <= 1'b0;
    seen(0, 10, 1'b0);
    @(posedge SYS_CLK);
    MASK_A <= 4'h1;
    AUTO_THR <= 16'h0010;
    seen(0, 20, 1'b1);
    chk(FLAGS[0], 1);
    @(posedge SYS_CLK);
    AUTO_THR <= 16'hffff;
    ramp <= 1'b0;
    TRIG_SEL <= 1'b0;
    cyc(140);
    rd(6'h03, cur);
    pa = PROC_A_RD;
    rd(6'h04, cur);
    chk(24'(PROC_A_RD - pa), 24'h000001);
    fin("select");
  endtask
  task automatic t_pm();
    logic [55:0] cur;
    logic [5:0] w;
    @(posedge SYS_CLK);
    PM_TRIG <= 1'b1;
    hit <= 4'hf;
    OFFSET <= {4{14'h0010}};
    CH_DELAY <= 16'h3210;
    cyc(2);
    PM_TRIG <= 1'b0;
    seen(9, 30, 1'b1);
    w = PM_WPTR;
    @(posedge SYS_CLK);
    hit <= 4'h0;
    rd(w - 6'h01, cur);
    chk(PM_RD, {4{14'h0f90}});
    rd(w - 6'h19, cur);
    chk(PM_RD, 56'h0);
    chk(PM_WPTR, w);
    cyc(12);
    @(posedge SYS_CLK);
    FLAG_CLR <= 5'h1f;
    cyc(3);
    FLAG_CLR <= 5'h00;
    @(negedge SYS_CLK);
    chk(FLAGS, 0);
    fin("postmortem");
  endtask
  ////////////////////////////////////////
  initial
  begin
    cyc(8);
    RST_N <= 1'b1;
    t_ctrl();
    t_ilk();
    t_coinc();
    t_cap();
    t_sel();
    t_pm();
    stop_test();
  end
  initial
  begin
    cyc(4000);
    err_total++;
    stop_test();
  end
endmodule // tb
